// ### common/cma_pkg.sv
// Constants and types for the mode-dependent address and register block.
// Assumes one core clock with a synchronous reset, and APB for software access.
// Overview of operation
// - Four modes chosen by mode pins
// - Normal mode keeps low 16 address bits
// - Normal vectors at VBR base, 16-bit entries
// - Normal mode stacks PC as 16 bits
// - Pointer carry propagates into upper half
// - Middle: program 16M, data 64K
// - Middle data address sign-extended from 16
// - Middle/advanced vectors: 32-bit, low 24 used
// - Memory-indirect branch via 8-bit address
// - Middle/advanced indirect operand top byte zero
// - Middle/advanced stack PC as 24 bits
// - Advanced: program 16M, data 4G
// - Maximum mode targets are full 32 bits
// - Maximum: 32-bit PC, extended control stacked
// - Fetch width from system control bit
// - Eight 32-bit general registers
// - Registers split into words and bytes
// - Operand size picks the index view
// - Last general register is stack pointer
// - PC bit 0 forced zero on fetch
// - Control registers with their widths
// - Branch conditions from N, Z, V, C
// - CONDITION_CODE_REG bit 7 mask, set on exception
package cma_pkg;
  typedef enum logic [1:0] {
    CMA_NORMAL = 2'h0, CMA_MIDDLE = 2'h1, CMA_ADVANCED = 2'h2, CMA_MAXIMUM = 2'h3
  } cma_mode_t;
  typedef enum logic [3:0] {
    CMA_OP_NONE, CMA_OP_EA_DATA, CMA_OP_EA_PROG, CMA_OP_VEC, CMA_OP_MIND, CMA_OP_TGT,
    CMA_OP_CALL, CMA_OP_RET, CMA_OP_EXC, CMA_OP_RTE, CMA_OP_WR, CMA_OP_RD,
    CMA_OP_INC, CMA_OP_DEC, CMA_OP_COND
  } cma_op_t;
  typedef enum logic [2:0] {
    CMA_SZ_BL, CMA_SZ_BH, CMA_SZ_WL, CMA_SZ_WH, CMA_SZ_L
  } cma_size_t;
  typedef struct packed {
    cma_op_t op;
    logic [2:0] rn;
    cma_size_t sz;
    logic [31:0] val;
    logic [15:0] aux;
  } cma_req_t;
  typedef struct packed {
    logic vld;
    logic [31:0] addr;
    logic [31:0] data;
    logic [15:0] ext;
    logic [2:0] bytes;
    logic flag;
  } cma_rsp_t;
  // APB byte offsets
  localparam logic [7:0] CMA_OFS_SYSTEM_CONTROL_REG = 8'h00;
  localparam logic [7:0] CMA_OFS_MODE = 8'h04;
  localparam logic [7:0] CMA_OFS_CCR = 8'h08;
  localparam logic [7:0] CMA_OFS_EXR = 8'h0C;
  localparam logic [7:0] CMA_OFS_VBR = 8'h10;
  localparam logic [7:0] CMA_OFS_SBR = 8'h14;
  localparam logic [7:0] CMA_OFS_MACH = 8'h18;
  localparam logic [7:0] CMA_OFS_MACL = 8'h1C;
  localparam logic [7:0] CMA_OFS_PC = 8'h20;
  localparam logic [7:0] CMA_OFS_GR = 8'h40;
  // Field positions and reset values
  localparam int CMA_FETCH_BIT = 0;
  localparam int CMA_CCR_I = 7;
  localparam int CMA_CCR_N = 3;
  localparam int CMA_CCR_Z = 2;
  localparam int CMA_CCR_V = 1;
  localparam int CMA_CCR_C = 0;
  localparam logic [7:0] CMA_CCR_RST = 8'h80;
  localparam logic [7:0] CMA_EXR_RST = 8'h7F;
  localparam logic [7:0] CMA_EXR_ONES = 8'h78;
  localparam logic [31:0] CMA_VBR_RST = 32'h00000000;
  localparam logic [31:0] CMA_VBR_MASK = 32'hFFFFF000;
  localparam logic [31:0] CMA_SBR_RST = 32'hFFFFFF00;
  localparam logic [31:0] CMA_SBR_MASK = 32'hFFFFFF00;
  localparam logic [31:0] CMA_PC_RST = 32'h00000000;
  localparam logic [31:0] CMA_MASK16 = 32'h0000FFFF;
  localparam logic [31:0] CMA_MASK24 = 32'h00FFFFFF;
  localparam logic [31:0] CMA_MASK32 = 32'hFFFFFFFF;
  localparam int CMA_MACH_BITS = 10;
  // Stack slot sizes in bytes
  localparam logic [31:0] CMA_SLOT_W = 32'h00000002;
  localparam logic [31:0] CMA_SLOT_L = 32'h00000004;
  localparam logic [31:0] CMA_FRAME_MAX = 32'h00000008;
endpackage : cma_pkg

// ### rtl/cma_core_regs.sv
// Mode-dependent address generation and the programmer-visible register set.
// Assumes a sequencer issuing one request per cycle and an APB master.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cma_core_regs
  import cma_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Mode pins
  input wire logic [1:0] mode_pins,
  // Core request and answer
  input wire cma_pkg::cma_req_t req,
  output cma_pkg::cma_rsp_t rsp,
  output logic [31:0] fetch_addr,
  output logic fetch_wide,
  output logic [1:0] mode,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import cma_pkg::*;

  if (AW < 7 || AW > 32)
  begin : g_chk
    $error("cma_core_regs: AW must be 7..32");
  end

  cma_mode_t mode_q;
  logic [31:0] gr_q [8];
  logic [31:0] pc_q, vbr_q, sbr_q, mach_q, macl_q;
  logic [7:0] ccr_q, exr_q;
  logic system_control_reg_q;
  cma_rsp_t rsp_q;
  logic [31:0] fetch_q, prdata_q;
  logic pready_q, pslverr_q;

  // ---------------------------------------------------------------
  // Mode dependent shaping
  // ---------------------------------------------------------------
  logic [31:0] sp, pc_mask, slot, frame, ea_data, view, vec_base;
  logic [2:0] nbytes;
  logic [31:0] delta;
  logic is_norm, is_max, cond_ok;

  always_comb
  begin
    is_norm = (mode_q == CMA_NORMAL);
    is_max = (mode_q == CMA_MAXIMUM);
    sp = gr_q[7];
    case (mode_q)
      CMA_NORMAL:
      begin
        pc_mask = CMA_MASK16;
        nbytes = 3'h2;
      end
      CMA_MIDDLE, CMA_ADVANCED:
      begin
        pc_mask = CMA_MASK24;
        nbytes = 3'h3;
      end
      default:
      begin
        pc_mask = CMA_MASK32;
        nbytes = 3'h4;
      end
    endcase
    slot = is_norm ? CMA_SLOT_W : CMA_SLOT_L;
    // PC plus CONDITION_CODE_REG word; maximum adds the extended control word
    frame = is_max ? CMA_FRAME_MAX : CMA_SLOT_L;
    case (mode_q)
      CMA_NORMAL: ea_data = req.val & CMA_MASK16;
      CMA_MIDDLE: ea_data = {8'h00, {8{req.val[15]}}, req.val[15:0]};
      default: ea_data = req.val;
    endcase
    // Reset vector ignores the base register
    vec_base = (req.val == 32'h00000000) ? 32'h00000000 : vbr_q;
    case (req.sz)
      CMA_SZ_BL: view = {24'h000000, gr_q[req.rn][7:0]};
      CMA_SZ_BH: view = {24'h000000, gr_q[req.rn][15:8]};
      CMA_SZ_WL: view = {16'h0000, gr_q[req.rn][15:0]};
      CMA_SZ_WH: view = {16'h0000, gr_q[req.rn][31:16]};
      default: view = gr_q[req.rn];
    endcase
    case (req.sz)
      CMA_SZ_BL, CMA_SZ_BH: delta = 32'h00000001;
      CMA_SZ_WL, CMA_SZ_WH: delta = 32'h00000002;
      default: delta = 32'h00000004;
    endcase
    case (req.val[3:0])
      4'h0: cond_ok = 1'b1;
      4'h1: cond_ok = 1'b0;
      4'h2: cond_ok = !(ccr_q[CMA_CCR_C] | ccr_q[CMA_CCR_Z]);
      4'h3: cond_ok = ccr_q[CMA_CCR_C] | ccr_q[CMA_CCR_Z];
      4'h4: cond_ok = !ccr_q[CMA_CCR_C];
      4'h5: cond_ok = ccr_q[CMA_CCR_C];
      4'h6: cond_ok = !ccr_q[CMA_CCR_Z];
      4'h7: cond_ok = ccr_q[CMA_CCR_Z];
      4'h8: cond_ok = !ccr_q[CMA_CCR_V];
      4'h9: cond_ok = ccr_q[CMA_CCR_V];
      4'hA: cond_ok = !ccr_q[CMA_CCR_N];
      4'hB: cond_ok = ccr_q[CMA_CCR_N];
      4'hC: cond_ok = !(ccr_q[CMA_CCR_N] ^ ccr_q[CMA_CCR_V]);
      4'hD: cond_ok = ccr_q[CMA_CCR_N] ^ ccr_q[CMA_CCR_V];
      4'hE: cond_ok = !(ccr_q[CMA_CCR_Z] | (ccr_q[CMA_CCR_N] ^ ccr_q[CMA_CCR_V]));
      default: cond_ok = ccr_q[CMA_CCR_Z] | (ccr_q[CMA_CCR_N] ^ ccr_q[CMA_CCR_V]);
    endcase
  end

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [7:0] ofs;
  logic hit, ro, wr_go;
  logic [31:0] rd_val;

  always_comb
  begin
    ofs = 8'(paddr);
    hit = 1'b1;
    ro = 1'b0;
    rd_val = 32'h00000000;
    if (AW > 8 && (paddr >> 8) != '0)
      hit = 1'b0;
    else if (ofs[7:5] == CMA_OFS_GR[7:5] && ofs[1:0] == 2'h0)
      rd_val = gr_q[ofs[4:2]];
    else
      case (ofs)
        CMA_OFS_SYSTEM_CONTROL_REG: rd_val = {31'h00000000, system_control_reg_q};
        CMA_OFS_MODE:
        begin
          rd_val = {30'h00000000, mode_q};
          ro = 1'b1;
        end
        CMA_OFS_CCR: rd_val = {24'h000000, ccr_q};
        CMA_OFS_EXR: rd_val = {24'h000000, exr_q};
        CMA_OFS_VBR: rd_val = vbr_q;
        CMA_OFS_SBR: rd_val = sbr_q;
        CMA_OFS_MACH: rd_val = mach_q;
        CMA_OFS_MACL: rd_val = macl_q;
        CMA_OFS_PC: rd_val = pc_q;
        default: hit = 1'b0;
      endcase
    // Write lands only at the edge where pready is seen high
    wr_go = psel & penable & pready_q & pwrite & hit & !ro;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      // One wait state: answer registered for flop-driven outputs
      pready_q <= psel & penable & !pready_q;
      pslverr_q <= psel & penable & !pready_q & !hit;
      prdata_q <= (psel & penable & !pready_q & !pwrite & hit) ? rd_val : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Mode capture
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      mode_q <= cma_mode_t'(mode_pins);
  end

  // ---------------------------------------------------------------
  // General registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
        gr_q[i] <= 32'h00000000;
    end
    else
    begin
      case (req.op)
        CMA_OP_WR:
          case (req.sz)
            CMA_SZ_BL: gr_q[req.rn][7:0] <= req.val[7:0];
            CMA_SZ_BH: gr_q[req.rn][15:8] <= req.val[7:0];
            CMA_SZ_WL: gr_q[req.rn][15:0] <= req.val[15:0];
            CMA_SZ_WH: gr_q[req.rn][31:16] <= req.val[15:0];
            default: gr_q[req.rn] <= req.val;
          endcase
        // Full-width add so the carry reaches the upper half
        CMA_OP_INC: gr_q[req.rn] <= gr_q[req.rn] + delta;
        CMA_OP_DEC: gr_q[req.rn] <= gr_q[req.rn] - delta;
        CMA_OP_CALL: gr_q[7] <= sp - slot;
        CMA_OP_RET: gr_q[7] <= sp + slot;
        CMA_OP_EXC: gr_q[7] <= sp - frame;
        CMA_OP_RTE: gr_q[7] <= sp + frame;
        default:
          if (wr_go && ofs[7:5] == CMA_OFS_GR[7:5])
            gr_q[ofs[4:2]] <= pwdata;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Program counter and fetch
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pc_q <= CMA_PC_RST;
      fetch_q <= CMA_PC_RST;
    end
    else
    begin
      if (req.op == CMA_OP_TGT || req.op == CMA_OP_RET || req.op == CMA_OP_RTE)
        pc_q <= req.val & pc_mask;
      else if (wr_go && ofs == CMA_OFS_PC)
        pc_q <= pwdata;
      fetch_q <= {pc_q[31:1], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ccr_q <= CMA_CCR_RST;
      exr_q <= CMA_EXR_RST;
    end
    else if (req.op == CMA_OP_EXC)
      ccr_q[CMA_CCR_I] <= 1'b1;
    else if (req.op == CMA_OP_RTE)
    begin
      ccr_q <= req.aux[7:0];
      if (is_max)
        exr_q <= req.aux[15:8] | CMA_EXR_ONES;
    end
    else
    begin
      if (wr_go && ofs == CMA_OFS_CCR)
        ccr_q <= pwdata[7:0];
      if (wr_go && ofs == CMA_OFS_EXR)
        exr_q <= pwdata[7:0] | CMA_EXR_ONES;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      vbr_q <= CMA_VBR_RST;
      sbr_q <= CMA_SBR_RST;
      mach_q <= 32'h00000000;
      macl_q <= 32'h00000000;
      system_control_reg_q <= 1'b0;
    end
    else if (wr_go)
    begin
      case (ofs)
        CMA_OFS_VBR: vbr_q <= pwdata & CMA_VBR_MASK;
        CMA_OFS_SBR: sbr_q <= pwdata & CMA_SBR_MASK;
        CMA_OFS_MACH:
          mach_q <= {{(32-CMA_MACH_BITS){pwdata[CMA_MACH_BITS-1]}}, pwdata[CMA_MACH_BITS-1:0]};
        CMA_OFS_MACL: macl_q <= pwdata;
        CMA_OFS_SYSTEM_CONTROL_REG: system_control_reg_q <= pwdata[CMA_FETCH_BIT];
        default: system_control_reg_q <= system_control_reg_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Answer to core requests
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      rsp_q <= '0;
    else
    begin
      rsp_q <= '0;
      rsp_q.vld <= (req.op != CMA_OP_NONE);
      rsp_q.bytes <= nbytes;
      case (req.op)
        CMA_OP_EA_DATA: rsp_q.addr <= ea_data;
        CMA_OP_EA_PROG: rsp_q.addr <= req.val & pc_mask;
        CMA_OP_VEC:
          rsp_q.addr <= vec_base + (is_norm ? {req.val[30:0], 1'b0} : {req.val[29:0], 2'h0});
        CMA_OP_MIND: rsp_q.addr <= {24'h000000, req.val[7:0]};
        CMA_OP_TGT, CMA_OP_RET, CMA_OP_RTE:
          rsp_q.data <= req.val & pc_mask;
        CMA_OP_CALL:
        begin
          rsp_q.addr <= sp - slot;
          rsp_q.data <= pc_q & pc_mask;
        end
        CMA_OP_EXC:
        begin
          rsp_q.addr <= sp - frame;
          rsp_q.data <= pc_q & pc_mask;
          rsp_q.ext <= {exr_q, ccr_q};
          rsp_q.flag <= is_max;
        end
        CMA_OP_RD: rsp_q.data <= view;
        CMA_OP_INC, CMA_OP_DEC: rsp_q.data <= gr_q[req.rn];
        CMA_OP_COND: rsp_q.flag <= cond_ok;
        default: rsp_q.addr <= 32'h00000000;
      endcase
    end
  end

  assign rsp = rsp_q;
  assign fetch_addr = fetch_q;
  assign fetch_wide = system_control_reg_q;
  assign mode = mode_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_norm_ea;
    (req.op == CMA_OP_EA_DATA && mode_q == CMA_NORMAL) |=> rsp.addr == ($past(req.val) & CMA_MASK16);
  endproperty
  a_norm_ea: assert property (p_norm_ea) else $error("normal data address not 16 bits");

  property p_mid_ea;
    (req.op == CMA_OP_EA_DATA && mode_q == CMA_MIDDLE) |=> rsp.addr[23:16] == {8{$past(req.val[15])}};
  endproperty
  a_mid_ea: assert property (p_mid_ea) else $error("middle data address not sign extended");

  property p_mid_tgt;
    (req.op == CMA_OP_TGT && (mode_q == CMA_MIDDLE || mode_q == CMA_ADVANCED)) |=> rsp.data[31:24] == 8'h00 && pc_q[31:24] == 8'h00;
  endproperty
  a_mid_tgt: assert property (p_mid_tgt) else $error("upper target byte not cleared");

  property p_max_tgt;
    (req.op == CMA_OP_TGT && mode_q == CMA_MAXIMUM) |=> pc_q == $past(req.val);
  endproperty
  a_max_tgt: assert property (p_max_tgt) else $error("maximum target altered");

  property p_norm_call;
    (req.op == CMA_OP_CALL && mode_q == CMA_NORMAL) |=> gr_q[7] == $past(gr_q[7]) - 32'h00000002 && rsp.bytes == 3'h2;
  endproperty
  a_norm_call: assert property (p_norm_call) else $error("normal call frame wrong");

  property p_exc_mask;
    req.op == CMA_OP_EXC |=> ccr_q[CMA_CCR_I];
  endproperty
  a_exc_mask: assert property (p_exc_mask) else $error("mask bit not set on exception");

  property p_mode_hold;
    ##1 1'b1 |-> $stable(mode_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

  property p_fetch_even;
    $changed(pc_q) |=> fetch_addr == {$past(pc_q[31:1]), 1'b0} && !fetch_addr[0];
  endproperty
  a_fetch_even: assert property (p_fetch_even) else $error("fetch address not even");

  property p_apb_wait;
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

  c_exc_max: cover property (req.op == CMA_OP_EXC && mode_q == CMA_MAXIMUM ##1 rsp.flag);
  c_mid_call: cover property (req.op == CMA_OP_CALL && mode_q == CMA_MIDDLE);
  c_apb_wr: cover property (psel && penable && pready && pwrite);
endmodule : cma_core_regs
`default_nettype wire

// ### bench/cma_mem_model.sv
// Memory model behind the address block: vectors, indirect pointers, stack.
// Assumes a push is the only answer with both address and data non-zero.
`timescale 1ns/1ps
`default_nettype none
module cma_mem_model
  import cma_pkg::*;
#(
  parameter int LAT = 2
) (
  // Clock
  input wire logic clock,
  // Block answers
  input wire cma_pkg::cma_rsp_t rsp,
  // Read return
  output logic [31:0] rd_data,
  output logic rd_vld
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] pend;
  int cnt = 0;
  initial
  begin
    rd_data = 32'h00000000;
    rd_vld = 1'b0;
  end
  always @(posedge clock)
  begin
    if (rsp.vld === 1'b1)
    begin
      // Every answer carries a byte count; only a push has address and word
      if (rsp.addr != 32'h00000000 && rsp.data != 32'h00000000)
      begin
        mem[rsp.addr] = rsp.data;
      end
      // Fresh words carry a non-zero top byte so masking shows
      pend = mem.exists(rsp.addr) ? mem[rsp.addr] : {8'hA5, rsp.addr[23:0] ^ 24'h3C5A97};
      cnt = LAT;
    end
    if (cnt > 0)
    begin
      cnt--;
      rd_vld <= (cnt == 0);
      rd_data <= pend;
    end
    else
    begin
      // Released bus inverts the held word every cycle
      rd_vld <= 1'b0;
      rd_data <= ~rd_data;
    end
  end
endmodule : cma_mem_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the mode-dependent address and register block.
// Assumes APB answers within a few cycles and the memory model returns reads.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cma_pkg::*;
  logic clock;
  logic rst = 1'b1;
  logic [1:0] mode_pins = 2'h0;
  logic [1:0] mode;
  cma_req_t req = '0;
  cma_rsp_t rsp;
  cma_rsp_t r;
  logic [31:0] fetch_addr, prdata, mem_data, d, pm;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fetch_wide, pready, pslverr, mem_vld, e;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] rv_ofs [4] = '{CMA_OFS_CCR, CMA_OFS_EXR, CMA_OFS_VBR, CMA_OFS_SBR};
  logic [31:0] rv_val [4] = '{32'h00000080, 32'h0000007F, 32'h00000000, 32'hFFFFFF00};
  logic [31:0] ea_exp [4] = '{32'h00008ABC, 32'h00FF8ABC, 32'h12348ABC, 32'h12348ABC};
  logic [31:0] vw_exp [5] = '{32'h00000044, 32'h000000AA, 32'h0000AA44, 32'h00001122, 32'h1122AA44};
  logic [31:0] pc_bytes [4] = '{32'h00000002, 32'h00000003, 32'h00000003, 32'h00000004};
  logic [15:0] cond_exp = 16'h9599;
  logic [15:0] cond_rte = 16'hA669;
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  cma_core_regs #(.AW(8)) i_cma_core_regs (.clock(clock), .rst(rst), .mode_pins(mode_pins), .req(req),
    .rsp(rsp), .fetch_addr(fetch_addr), .fetch_wide(fetch_wide), .mode(mode), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cma_mem_model #(.LAT(2)) i_cma_mem_model (.clock(clock), .rsp(rsp), .rd_data(mem_data), .rd_vld(mem_vld));
  // ----
  // Tasks
  // ----
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(inout int n);
    n++;
    if (n > 20)
    begin
      error_cnt++;
      $display("ERROR at %0t: no answer", $time);
      conclude();
    end
    else
      @(posedge clock);
  endtask : tick
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd = 32'h00000000);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    while (pready !== 1'b1)
      tick(n);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic core(input cma_op_t op, input logic [31:0] val = 32'h00000000, input logic [2:0] rn = 3'h0,
                      input cma_size_t sz = CMA_SZ_L, input logic [15:0] aux = 16'h0000);
    @(posedge clock);
    req <= '{op: op, rn: rn, sz: sz, val: val, aux: aux};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
    r = rsp;
  endtask : core
  task automatic mem_read;
    int n = 0;
    while (mem_vld !== 1'b1)
      tick(n);
    d = mem_data;
  endtask : mem_read
  // ----
  // Sequence, one pass per mode
  // ----
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clock);
      rst <= 1'b1;
      mode_pins <= m[1:0];
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      mode_pins <= ~m[1:0];
      pm = (m == 0) ? 32'h0000FFFF : (m == 3) ? 32'hFFFFFFFF : 32'h00FFFFFF;
      for (int k = 0; k < 4; k++)
      begin
        apb(1'b0, rv_ofs[k]);
        chk(d, rv_val[k], "reset value");
      end
      core(CMA_OP_EA_DATA, 32'h12348ABC);
      chk(r.addr, ea_exp[m], "data addr");
      chk({31'h0, r.vld}, 32'h00000001, "answer valid");
      core(CMA_OP_EA_PROG, 32'hFEDCBA98);
      chk(r.addr, 32'hFEDCBA98 & pm, "prog addr");
      core(CMA_OP_VEC, 32'h00000005);
      chk(r.addr, (m == 0) ? 32'h0000000A : 32'h00000014, "vector addr");
      mem_read();
      core(CMA_OP_TGT, d);
      chk(r.data, d & pm, "vector target");
      core(CMA_OP_MIND, 32'h000001C7);
      chk(r.addr, 32'h000000C7, "indirect ptr");
      mem_read();
      core(CMA_OP_TGT, d);
      chk(r.data, d & pm, "indirect target");
      core(CMA_OP_TGT, 32'h89ABCDEF);
      @(posedge clock);
      chk(fetch_addr, 32'h89ABCDEE & pm, "fetch addr");
      core(CMA_OP_WR, 32'h00002000, 3'h7);
      core(CMA_OP_CALL);
      chk(r.addr, (m == 0) ? 32'h00001FFE : 32'h00001FFC, "push addr");
      chk(r.data, 32'h89ABCDEF & pm, "pushed pc");
      chk({29'h0, r.bytes}, pc_bytes[m], "pc width");
      core(CMA_OP_RET, 32'h00000100);
      core(CMA_OP_RD, 32'h00000000, 3'h7);
      chk(r.data, 32'h00002000, "sp after return");
      apb(1'b1, CMA_OFS_CCR, 32'h00000004);
      core(CMA_OP_EXC);
      chk({16'h0, r.ext}, 32'h00007F04, "saved control");
      chk({31'h0, r.flag}, (m == 3), "control frame");
      apb(1'b0, CMA_OFS_CCR);
      chk(d, 32'h00000084, "mask on entry");
      core(CMA_OP_RD, 32'h00000000, 3'h7);
      chk(r.data, (m == 3) ? 32'h00001FF8 : 32'h00001FFC, "exception frame");
      for (int k = 0; k < 16; k++)
      begin
        core(CMA_OP_COND, k);
        chk({31'h0, r.flag}, cond_exp[k], "condition");
      end
      core(CMA_OP_RTE, 32'h00000200, 3'h0, CMA_SZ_L, 16'h0183);
      apb(1'b0, CMA_OFS_EXR);
      chk(d, (m == 3) ? 32'h00000079 : 32'h0000007F, "restored ext");
      for (int k = 0; k < 16; k++)
      begin
        core(CMA_OP_COND, k);
        chk({31'h0, r.flag}, cond_rte[k], "condition after return");
      end
      core(CMA_OP_WR, 32'h11223344, 3'h2);
      core(CMA_OP_WR, 32'h000000AA, 3'h2, CMA_SZ_BH);
      for (int k = 0; k < 5; k++)
      begin
        core(CMA_OP_RD, 32'h00000000, 3'h2, cma_size_t'(k));
        chk(r.data, vw_exp[k], "view");
      end
      apb(1'b0, CMA_OFS_GR + 8'h08);
      chk(d, 32'h1122AA44, "register by bus");
      core(CMA_OP_WR, 32'h0000FFFF, 3'h3);
      core(CMA_OP_INC, 32'h00000000, 3'h3, CMA_SZ_WL);
      chk(r.data, 32'h0000FFFF, "pointer before inc");
      core(CMA_OP_RD, 32'h00000000, 3'h3);
      chk(r.data, 32'h00010001, "pointer carry");
      core(CMA_OP_DEC, 32'h00000000, 3'h3, CMA_SZ_WL);
      chk(r.data, 32'h00010001, "pointer before dec");
      core(CMA_OP_RD, 32'h00000000, 3'h3);
      chk(r.data, 32'h0000FFFF, "pointer borrow");
      apb(1'b1, 8'h30, 32'hFFFFFFFF);
      chk({31'h0, e}, 32'h00000001, "unmapped");
      apb(1'b1, CMA_OFS_VBR, 32'h12345678);
      apb(1'b0, CMA_OFS_VBR);
      chk(d, 32'h12345000, "vector base");
      core(CMA_OP_VEC, 32'h00000005);
      chk(r.addr, (m == 0) ? 32'h1234500A : 32'h12345014, "based vector");
      core(CMA_OP_VEC, 32'h00000000);
      chk(r.addr, 32'h00000000, "reset vector");
      apb(1'b1, CMA_OFS_MACH, 32'h00000300);
      apb(1'b0, CMA_OFS_MACH);
      chk(d, 32'hFFFFFF00, "mac high");
      apb(1'b1, CMA_OFS_MODE, {30'h0, ~m[1:0]});
      chk({31'h0, e}, 32'h00000000, "mode write");
      apb(1'b0, CMA_OFS_MODE);
      chk(d, m, "mode by bus");
      apb(1'b1, CMA_OFS_SYSTEM_CONTROL_REG, 32'h00000001);
      @(posedge clock);
      chk({31'h0, fetch_wide}, 32'h00000001, "fetch width");
      core(CMA_OP_EA_DATA, 32'h12348ABC);
      chk(r.addr, ea_exp[m], "data addr wide");
      chk({30'h0, mode}, m, "mode");
      $display("Mode %0d checks done", m);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
